//--- src/oflb_pkg.sv
package oflb_pkg;

    // =====================================================================
    // widths and depth
    localparam int DATA_W = 9;
    localparam int BYTE_W = 8;
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;
    localparam int OFS_W = 9;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 10'h200;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

    // =====================================================================
    // offset defaults: seven words from either end
    localparam logic [BYTE_W-1:0] OFS_LO_DEFAULT = 8'h07;
    localparam logic [BYTE_W-1:0] OFS_HI_DEFAULT = 8'h00;
    localparam logic [OFS_W-1:0] OFS_DEFAULT = 9'h007;

    // =====================================================================
    // offset register selection, walked in this order for writes and reads
    typedef enum logic [1:0] {
        OFLB_SEL_EMPTY_LO = 2'b00,
        OFLB_SEL_EMPTY_HI = 2'b01,
        OFLB_SEL_FULL_LO = 2'b10,
        OFLB_SEL_FULL_HI = 2'b11
    } oflb_sel_t;

    // =====================================================================
    // status flags, all active low as seen on the pins
    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } oflb_flags_t;

    localparam oflb_flags_t FLAGS_RESET = 4'h5;

    // =====================================================================
    // register port map
    localparam int ADDR_W = 4;
    localparam int REG_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_OFFSETS = 4'h8;
    localparam int CTRL_RESTORE_BIT = 0;
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_FLAGS_LSB = 16;
    localparam int ST_MODE_BIT = 20;
    localparam int ST_SEL_LSB = 21;
    localparam int OFS_N_LSB = 0;
    localparam int OFS_M_LSB = 16;

    // an offset is the low byte plus the lowest bit of the high byte
    function automatic logic [OFS_W-1:0] ofs_join(input logic [BYTE_W-1:0] lo, input logic [BYTE_W-1:0] hi);
        ofs_join = {hi[0], lo};
    endfunction

endpackage

//--- src/oflb_offset_bank.sv
`timescale 1ns/10ps
`default_nettype none

module oflb_offset_bank (
    input wire logic sys_clk_in, // system clock
    input wire logic srst_in, // synchronous reset
    input wire logic wr_in, // load one offset byte
    input wire logic rd_in, // read back one offset byte
    input wire logic restore_in, // return offsets to defaults
    input wire logic [oflb_pkg::BYTE_W-1:0] data_in, // byte to load
    output logic [oflb_pkg::DATA_W-1:0] rd_data_out, // selected byte, zero extended
    output logic [oflb_pkg::OFS_W-1:0] n_out, // empty offset
    output logic [oflb_pkg::OFS_W-1:0] m_out, // full offset
    output oflb_pkg::oflb_sel_t sel_out // current selection
);

    logic [oflb_pkg::BYTE_W-1:0] byte_r [4];
    oflb_pkg::oflb_sel_t sel_r;
    oflb_pkg::oflb_sel_t sel_nxt;

    // =====================================================================
    // selection pointer, shared by loads and readback
    always_comb begin
        case (sel_r)
            oflb_pkg::OFLB_SEL_EMPTY_LO: sel_nxt = oflb_pkg::OFLB_SEL_EMPTY_HI;
            oflb_pkg::OFLB_SEL_EMPTY_HI: sel_nxt = oflb_pkg::OFLB_SEL_FULL_LO;
            oflb_pkg::OFLB_SEL_FULL_LO: sel_nxt = oflb_pkg::OFLB_SEL_FULL_HI;
            oflb_pkg::OFLB_SEL_FULL_HI: sel_nxt = oflb_pkg::OFLB_SEL_EMPTY_LO;
            default: sel_nxt = oflb_pkg::OFLB_SEL_EMPTY_LO;
        endcase
    end

    // not reset by a return to normal mode, so a partial load resumes
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sel_r <= oflb_pkg::OFLB_SEL_EMPTY_LO;
        end else if (wr_in || rd_in) begin
            sel_r <= sel_nxt;
        end
    end

    // =====================================================================
    // the four offset bytes
    always_ff @(posedge sys_clk_in) begin
        if (srst_in || restore_in) begin
            byte_r[0] <= oflb_pkg::OFS_LO_DEFAULT;
            byte_r[1] <= oflb_pkg::OFS_HI_DEFAULT;
            byte_r[2] <= oflb_pkg::OFS_LO_DEFAULT;
            byte_r[3] <= oflb_pkg::OFS_HI_DEFAULT;
        end else if (wr_in) begin
            byte_r[sel_r] <= data_in;
        end
    end

    assign rd_data_out = {1'b0, byte_r[sel_r]};
    assign n_out = oflb_pkg::ofs_join(byte_r[0], byte_r[1]);
    assign m_out = oflb_pkg::ofs_join(byte_r[2], byte_r[3]);
    assign sel_out = sel_r;

endmodule

`default_nettype wire

//--- src/oflb_flag_calc.sv
`timescale 1ns/10ps
`default_nettype none

module oflb_flag_calc (
    input wire logic sys_clk_in, // system clock
    input wire logic srst_in, // synchronous reset
    input wire logic [oflb_pkg::CNT_W-1:0] count_nxt_in, // unread words after this edge
    input wire logic [oflb_pkg::OFS_W-1:0] n_in, // empty offset
    input wire logic [oflb_pkg::OFS_W-1:0] m_in, // full offset
    output oflb_pkg::oflb_flags_t flags_out // registered flags
);

    logic [oflb_pkg::CNT_W-1:0] free_nxt;

    assign free_nxt = oflb_pkg::DEPTH_CNT - count_nxt_in;

    // one flop per flag, all refreshed on every edge
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            flags_out <= oflb_pkg::FLAGS_RESET;
        end else begin
            flags_out.empty_n <= (count_nxt_in != oflb_pkg::CNT_ZERO);
            flags_out.full_n <= (count_nxt_in != oflb_pkg::DEPTH_CNT);
            flags_out.almost_empty_n <= (count_nxt_in > {1'b0, n_in});
            flags_out.almost_full_n <= (free_nxt > {1'b0, m_in});
        end
    end

endmodule

`default_nettype wire

//--- src/oflb_fifo_core.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - in load mode, low load and enable write offsets in order el, eh, fl, fh
// - after the full high byte, the next offset load goes to empty low
// - leaving load mode keeps the position; next load uses the following register
// - in load mode with load low and both read enables low, an edge outputs the selected offset
// - offset readback steps through the same four-register order as loads
// - enable high does nothing; load high with enable low writes the FIFO
// - almost flags come from the offsets and the unread word count
// - almost-empty is one flop, low at n or fewer unread words
// - almost-empty goes high at n plus one or more unread words
// - almost-full is one flop, low at depth minus m or more words
// - almost-full goes high when free locations exceed m
// - both offsets default to seven
// - full flag low when full, and then every write is blocked
// - full flag is refreshed on every clock edge
// - empty flag low when empty, and then every read is blocked
// - empty flag is refreshed on every clock edge
// - load pin sampled at reset: low means offset load, high second write enable
// - four eight-bit offset registers, loaded and read back through the data pins
// - a normal read needs both read enables low and a non-empty FIFO
module oflb_fifo_core (
    input wire logic sys_clk_in, // system clock, 250 MHz
    input wire logic srst_in, // synchronous reset, active high
    input wire logic [oflb_pkg::DATA_W-1:0] data_in, // write data
    input wire logic primary_write_enable_n_in, // primary write enable, active low
    input wire logic load_select_in, // load select or second write enable
    input wire logic read_enable_first_n_in, // first read enable, active low
    input wire logic read_enable_second_n_in, // second read enable, active low
    output logic [oflb_pkg::DATA_W-1:0] data_out, // read data, registered
    output logic empty_indicator_n_out, // low when empty
    output logic full_indicator_n_out, // low when full
    output logic almost_empty_indicator_n_out, // low when almost empty
    output logic almost_full_indicator_n_out, // low when almost full
    input wire logic [oflb_pkg::ADDR_W-1:0] reg_addr_in, // register byte address
    input wire logic [oflb_pkg::REG_W-1:0] reg_wdata_in, // register write data
    input wire logic reg_wr_in, // register write strobe
    input wire logic reg_rd_in, // register read strobe
    output logic [oflb_pkg::REG_W-1:0] reg_rdata_out // register read data, next cycle
);

    logic [oflb_pkg::DATA_W-1:0] mem [2**oflb_pkg::PTR_W];
    logic [oflb_pkg::PTR_W-1:0] wptr_r;
    logic [oflb_pkg::PTR_W-1:0] rptr_r;
    logic [oflb_pkg::CNT_W-1:0] count_r;
    logic [oflb_pkg::CNT_W-1:0] count_nxt;
    logic mode_prog_r;
    logic restore_r;
    oflb_pkg::oflb_flags_t flags;
    logic [oflb_pkg::OFS_W-1:0] n_ofs;
    logic [oflb_pkg::OFS_W-1:0] m_ofs;
    oflb_pkg::oflb_sel_t sel;
    logic [oflb_pkg::DATA_W-1:0] ofs_rd_data;
    logic wen_active;
    logic ren_active;
    logic fifo_wr;
    logic fifo_rd;
    logic ofs_wr;
    logic ofs_rd;
    logic [oflb_pkg::REG_W-1:0] status_word;
    logic [oflb_pkg::REG_W-1:0] offsets_word;

    // =====================================================================
    // pin mode, caught while reset is high
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mode_prog_r <= !load_select_in;
        end
    end

    // =====================================================================
    // operation decode
    assign wen_active = !primary_write_enable_n_in;
    assign ren_active = !read_enable_first_n_in && !read_enable_second_n_in;

    // the full and empty flags gate every kind of access, offset ones included
    always_comb begin
        fifo_wr = 1'b0;
        ofs_wr = 1'b0;
        if (!srst_in && flags.full_n && wen_active) begin
            if (mode_prog_r && !load_select_in) begin
                ofs_wr = 1'b1;
            end else if (load_select_in) begin
                fifo_wr = 1'b1;
            end
        end
    end

    always_comb begin
        fifo_rd = 1'b0;
        ofs_rd = 1'b0;
        if (!srst_in && flags.empty_n && ren_active) begin
            if (mode_prog_r && !load_select_in) begin
                ofs_rd = 1'b1;
            end else begin
                fifo_rd = 1'b1;
            end
        end
    end

    // =====================================================================
    // storage and pointers
    always_ff @(posedge sys_clk_in) begin
        if (fifo_wr) begin
            mem[wptr_r] <= data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            wptr_r <= '0;
        end else if (fifo_wr) begin
            wptr_r <= wptr_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rptr_r <= '0;
        end else if (fifo_rd) begin
            rptr_r <= rptr_r + 1'b1;
        end
    end

    // unread word count stands for the write/read pointer difference
    always_comb begin
        count_nxt = count_r;
        if (fifo_wr && !fifo_rd) begin
            count_nxt = count_r + oflb_pkg::CNT_ONE;
        end else if (fifo_rd && !fifo_wr) begin
            count_nxt = count_r - oflb_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            count_r <= oflb_pkg::CNT_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end

    // an empty FIFO keeps the last word it put out
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            data_out <= '0;
        end else if (ofs_rd) begin
            data_out <= ofs_rd_data;
        end else if (fifo_rd) begin
            data_out <= mem[rptr_r];
        end
    end

    // =====================================================================
    // offsets and flags
    oflb_offset_bank u_bank (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .wr_in(ofs_wr),
        .rd_in(ofs_rd),
        .restore_in(restore_r),
        .data_in(data_in[oflb_pkg::BYTE_W-1:0]),
        .rd_data_out(ofs_rd_data),
        .n_out(n_ofs),
        .m_out(m_ofs),
        .sel_out(sel)
    );

    oflb_flag_calc u_flags (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .count_nxt_in(count_nxt),
        .n_in(n_ofs),
        .m_in(m_ofs),
        .flags_out(flags)
    );

    assign empty_indicator_n_out = flags.empty_n;
    assign full_indicator_n_out = flags.full_n;
    assign almost_empty_indicator_n_out = flags.almost_empty_n;
    assign almost_full_indicator_n_out = flags.almost_full_n;

    // =====================================================================
    // register port
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            restore_r <= 1'b0;
        end else begin
            restore_r <= reg_wr_in && (reg_addr_in == oflb_pkg::REG_CTRL) && reg_wdata_in[oflb_pkg::CTRL_RESTORE_BIT];
        end
    end

    always_comb begin
        status_word = '0;
        status_word[oflb_pkg::ST_COUNT_LSB +: oflb_pkg::CNT_W] = count_r;
        status_word[oflb_pkg::ST_FLAGS_LSB +: 4] = flags;
        status_word[oflb_pkg::ST_MODE_BIT] = mode_prog_r;
        status_word[oflb_pkg::ST_SEL_LSB +: 2] = sel;
        offsets_word = '0;
        offsets_word[oflb_pkg::OFS_N_LSB +: oflb_pkg::OFS_W] = n_ofs;
        offsets_word[oflb_pkg::OFS_M_LSB +: oflb_pkg::OFS_W] = m_ofs;
    end

    // unmapped and control addresses read as zero
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in && reg_addr_in == oflb_pkg::REG_STATUS) begin
            reg_rdata_out <= status_word;
        end else if (reg_rd_in && reg_addr_in == oflb_pkg::REG_OFFSETS) begin
            reg_rdata_out <= offsets_word;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);

    logic cfg_chg_q;
    always_ff @(posedge sys_clk_in) begin
        cfg_chg_q <= ofs_wr || restore_r || srst_in;
    end

    property p_load_first;
        ofs_wr && sel == oflb_pkg::OFLB_SEL_EMPTY_LO |=> n_ofs[7:0] == $past(data_in[7:0]) && sel == oflb_pkg::OFLB_SEL_EMPTY_HI;
    endproperty
    a_load_first: assert property (p_load_first) else $error("empty low offset not loaded");

    property p_wrap;
        ofs_wr && sel == oflb_pkg::OFLB_SEL_FULL_HI |=> sel == oflb_pkg::OFLB_SEL_EMPTY_LO;
    endproperty
    a_wrap: assert property (p_wrap) else $error("offset selection did not wrap");

    property p_sel_hold;
        !ofs_wr && !ofs_rd |=> $stable(sel);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("selection moved without offset access");

    property p_readback;
        ofs_rd |=> data_out == $past(ofs_rd_data) && sel != $past(sel);
    endproperty
    a_readback: assert property (p_readback) else $error("offset readback wrong");

    property p_no_op;
        mode_prog_r && !primary_write_enable_n_in == 1'b0 |-> !fifo_wr && !ofs_wr;
    endproperty
    a_no_op: assert property (p_no_op) else $error("write with enable high");

    property p_ae;
        !cfg_chg_q |-> almost_empty_indicator_n_out == (count_r > {1'b0, n_ofs});
    endproperty
    a_ae: assert property (p_ae) else $error("almost-empty flag wrong");

    property p_af;
        !cfg_chg_q |-> almost_full_indicator_n_out == ((oflb_pkg::DEPTH_CNT - count_r) > {1'b0, m_ofs});
    endproperty
    a_af: assert property (p_af) else $error("almost-full flag wrong");

    property p_full_block;
        !full_indicator_n_out |-> !fifo_wr && !ofs_wr ##1 full_indicator_n_out == (count_r != oflb_pkg::DEPTH_CNT);
    endproperty
    a_full_block: assert property (p_full_block) else $error("write while full");

    property p_empty_block;
        !empty_indicator_n_out |-> !fifo_rd && !ofs_rd ##1 empty_indicator_n_out == (count_r != oflb_pkg::CNT_ZERO);
    endproperty
    a_empty_block: assert property (p_empty_block) else $error("read while empty");

    property p_reset_state;
        $fell(srst_in) |-> n_ofs == oflb_pkg::OFS_DEFAULT && m_ofs == oflb_pkg::OFS_DEFAULT
            && sel == oflb_pkg::OFLB_SEL_EMPTY_LO && mode_prog_r == !$past(load_select_in);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_fifo_read;
        fifo_rd |=> data_out == $past(mem[rptr_r]) && count_r == $past(count_nxt);
    endproperty
    a_fifo_read: assert property (p_fifo_read) else $error("fifo read data wrong");

    property p_fifo_write;
        fifo_wr |=> mem[$past(wptr_r)] == $past(data_in);
    endproperty
    a_fifo_write: assert property (p_fifo_write) else $error("fifo write lost");

    property p_two_en;
        !mode_prog_r && !load_select_in |-> !fifo_wr && !ofs_wr && !ofs_rd;
    endproperty
    a_two_en: assert property (p_two_en) else $error("access with second enable low");

    property p_mode_hold;
        !srst_in |=> $stable(mode_prog_r);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("pin mode changed outside reset");

    property p_sel_step;
        ofs_rd |=> sel == 2'($past(sel) + 2'b01);
    endproperty
    a_sel_step: assert property (p_sel_step) else $error("readback order wrong");

    property p_ae_high;
        !cfg_chg_q && count_r >= {1'b0, n_ofs} + oflb_pkg::CNT_ONE |-> almost_empty_indicator_n_out;
    endproperty
    a_ae_high: assert property (p_ae_high) else $error("almost-empty flag not high");

    property p_af_low;
        !cfg_chg_q && count_r >= oflb_pkg::DEPTH_CNT - {1'b0, m_ofs} |-> !almost_full_indicator_n_out;
    endproperty
    a_af_low: assert property (p_af_low) else $error("almost-full flag not low");

    property p_full_track;
        full_indicator_n_out == (count_r != oflb_pkg::DEPTH_CNT);
    endproperty
    a_full_track: assert property (p_full_track) else $error("full flag stale");

    property p_empty_track;
        empty_indicator_n_out == (count_r != oflb_pkg::CNT_ZERO);
    endproperty
    a_empty_track: assert property (p_empty_track) else $error("empty flag stale");

    property p_half_read;
        read_enable_first_n_in || read_enable_second_n_in |-> !fifo_rd && !ofs_rd;
    endproperty
    a_half_read: assert property (p_half_read) else $error("read with one enable high");

    property p_data_hold;
        !fifo_rd && !ofs_rd |=> $stable(data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("output moved without a read");

    c_wrap: cover property (ofs_wr && sel == oflb_pkg::OFLB_SEL_FULL_HI);
    c_full: cover property (!full_indicator_n_out);
    c_readback: cover property (ofs_rd);
    c_ae_rise: cover property ($rose(almost_empty_indicator_n_out));
    c_two_en: cover property (!mode_prog_r && fifo_wr);

endmodule

`default_nettype wire

//--- verif/oflb_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================================
// system logic on the pin side: one single device, no width expansion
module oflb_pin_model (
    input wire logic sys_clk_in, // system clock
    input wire logic srst_in, // reset seen by the fifo
    output logic [oflb_pkg::DATA_W-1:0] data_out, // write data pins
    output logic wen_n_out, // primary write enable, active low
    output logic load_out, // load select
    output logic read_enable_first_n_out, // first read enable, active low
    output logic read_enable_second_n_out // second read enable, active low
);
    logic reset_load;

    initial begin
        reset_load = 1'b0;
        data_out = 9'h1AA;
        wen_n_out = 1'b1;
        load_out = 1'b0;
        read_enable_first_n_out = 1'b1;
        read_enable_second_n_out = 1'b1;
    end

    // load select level through reset picks the mode, low for offset load
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            load_out <= reset_load;
        end
    end

    // one access per call, so offset loads and readbacks never overlap
    // a single device: its own empty and full pins are the composite flags
    task automatic op(input logic w, input logic l, input logic r1, input logic r2,
                      input logic [oflb_pkg::DATA_W-1:0] d);
        @(posedge sys_clk_in);
        wen_n_out <= w;
        load_out <= l;
        read_enable_first_n_out <= r1;
        read_enable_second_n_out <= r2;
        data_out <= d;
        @(posedge sys_clk_in);
        wen_n_out <= 1'b1;
        load_out <= 1'b1;
        read_enable_first_n_out <= 1'b1;
        read_enable_second_n_out <= 1'b1;
        // stale data is inverted so it never passes for the last word
        data_out <= ~d;
        #1;
    endtask
endmodule

`default_nettype wire

//--- verif/oflb_fifo_core_test.sv
`timescale 1ns/10ps
`default_nettype none

module oflb_fifo_core_test;
    logic sys_clk_in;
    logic srst_in;
    logic [8:0] d;
    logic wen_n;
    logic ld;
    logic r1_n;
    logic r2_n;
    logic [8:0] q_out;
    logic ef_n;
    logic ff_n;
    logic ae_n;
    logic af_n;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    int err_count = 0;
    int n_tests = 0;
    int cnt;
    logic [7:0] ob [4];
    logic [1:0] sel;
    logic prog;
    logic [8:0] last;
    logic [8:0] q [$];

    oflb_pin_model i_pm (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .data_out(d), .wen_n_out(wen_n),
        .load_out(ld), .read_enable_first_n_out(r1_n), .read_enable_second_n_out(r2_n));

    oflb_fifo_core i_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .data_in(d),
        .primary_write_enable_n_in(wen_n), .load_select_in(ld), .read_enable_first_n_in(r1_n),
        .read_enable_second_n_in(r2_n), .data_out(q_out), .empty_indicator_n_out(ef_n),
        .full_indicator_n_out(ff_n), .almost_empty_indicator_n_out(ae_n),
        .almost_full_indicator_n_out(af_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // =====================================================================
    // checking
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    function automatic logic [3:0] fl_exp();
        logic [8:0] n;
        logic [8:0] m;
        n = {ob[1][0], ob[0]};
        m = {ob[3][0], ob[2]};
        return {cnt != 0, cnt != 512, cnt > n, cnt < 512 - m};
    endfunction

    task automatic chk_fl();
        chk("flags", {28'h0, fl_exp()}, {28'h0, ef_n, ff_n, ae_n, af_n});
        chk("data_out", {23'h0, last}, {23'h0, q_out});
    endtask

    // =====================================================================
    // register port
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask

    task automatic chk_ofs();
        reg_rd(oflb_pkg::REG_OFFSETS, {7'h0, ob[3][0], ob[2], 7'h0, ob[1][0], ob[0]}, "offsets");
        reg_rd(oflb_pkg::REG_STATUS, {9'h0, sel, prog, fl_exp(), 6'h0, 10'(cnt)}, "status");
    endtask

    // =====================================================================
    // pin accesses with the expected effect tracked alongside
    task automatic push(input logic [8:0] v);
        i_pm.op(1'b0, 1'b1, 1'b1, 1'b1, v);
        if (cnt < 512) begin
            q.push_back(v);
            cnt++;
        end
        chk_fl();
    endtask

    task automatic ldo(input logic [7:0] b);
        i_pm.op(1'b0, 1'b0, 1'b1, 1'b1, {1'b0, b});
        if (cnt < 512 && prog) begin
            ob[sel] = b;
            sel++;
        end
        chk_fl();
    endtask

    task automatic pop();
        i_pm.op(1'b1, 1'b1, 1'b0, 1'b0, 9'h0);
        if (cnt > 0) begin
            last = q.pop_front();
            cnt--;
        end
        chk_fl();
    endtask

    task automatic rbk();
        i_pm.op(1'b1, 1'b0, 1'b0, 1'b0, 9'h0);
        if (cnt > 0) begin
            last = {1'b0, ob[sel]};
            sel++;
        end
        chk_fl();
    endtask

    // an access that must leave count, offsets and output alone
    task automatic nop(input logic w, input logic l, input logic r1, input logic r2);
        i_pm.op(w, l, r1, r2, 9'h0F0);
        chk_fl();
    endtask

    initial begin
        #100000;
        err_count++;
        $display("CHECK FAILED watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        srst_in = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        cnt = 0;
        sel = 2'h0;
        last = 9'h0;
        prog = 1'b1;
        ob = '{8'h07, 8'h00, 8'h07, 8'h00};
        repeat (8) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
        chk_fl();
        chk_ofs();
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            push(9'(k + 9'h100));
        end
        $display("test almost empty done");
        ldo(8'h03);
        ldo(8'h00);
        push(9'h1F0);
        ldo(8'h02);
        ldo(8'h01);
        ldo(8'h05);
        chk_ofs();
        for (int k = 0; k < 4; k++) begin
            rbk();
        end
        nop(1'b1, 1'b0, 1'b1, 1'b1);
        nop(1'b1, 1'b1, 1'b1, 1'b1);
        nop(1'b1, 1'b1, 1'b0, 1'b1);
        nop(1'b1, 1'b0, 1'b1, 1'b0);
        chk_ofs();
        $display("test offset load and readback done");
        while (cnt < 512) begin
            push(9'(cnt) ^ 9'h155);
        end
        push(9'h0AA);
        ldo(8'h11);
        chk_ofs();
        $display("test fill done");
        while (cnt > 0) begin
            pop();
        end
        pop();
        rbk();
        $display("test drain done");
        reg_wr(oflb_pkg::REG_CTRL, 32'h0000_0001);
        ob = '{8'h07, ob[1], 8'h07, ob[3]};
        ob[1] = 8'h00;
        ob[3] = 8'h00;
        chk_ofs();
        reg_rd(4'hC, 32'h0, "unmapped");
        $display("test registers done");
        // second reset with load select high: two write enables, no offset access
        i_pm.reset_load = 1'b1;
        @(posedge sys_clk_in);
        srst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        cnt = 0;
        sel = 2'h0;
        last = 9'h0;
        prog = 1'b0;
        ob = '{8'h07, 8'h00, 8'h07, 8'h00};
        @(posedge sys_clk_in);
        #1;
        chk_fl();
        ldo(8'h33);
        push(9'h123);
        pop();
        chk_ofs();
        $display("test two write enables done");
        stop_test();
    end
endmodule

`default_nettype wire
